// File: logic/oscx_pkg.sv
// Package of offsets, field layout, reset values and types for the oscillator status and control block.
package oscx_pkg;

  // ********************************************************
  // Register map
  // ********************************************************
  localparam logic [7:0]  OSCX_OFS_INT_ENABLE = 8'h00;
  localparam logic [7:0]  OSCX_OFS_INT_FLAG   = 8'h08;
  localparam logic [7:0]  OSCX_OFS_STATUS     = 8'h0C;
  localparam logic [7:0]  OSCX_OFS_CONTROL    = 8'h10;

  localparam logic [31:0] OSCX_STATUS_RST     = 32'h0000_0000;
  localparam logic [15:0] OSCX_CONTROL_RST    = 16'h0080;
  localparam logic [11:0] OSCX_FLAG_RST       = 12'h000;
  localparam logic [11:0] OSCX_ENABLE_RST     = 12'h000;

  // ********************************************************
  // Status bit positions
  // ********************************************************
  localparam int OSCX_ST_BROWNOUT_SYNC_BUSY  = 11;
  localparam int OSCX_ST_BROWNOUT_DETECTED   = 10;
  localparam int OSCX_ST_BROWNOUT_READY      = 9;
  localparam int OSCX_ST_LOOP_REFCLK_STOPPED = 8;
  localparam int OSCX_ST_LOOP_COARSE_LOCK    = 7;
  localparam int OSCX_ST_LOOP_FINE_LOCK      = 6;
  localparam int OSCX_ST_LOOP_OUT_OF_BOUNDS  = 5;
  localparam int OSCX_ST_LOOP_SYNC_STATUS    = 4;
  localparam int OSCX_ST_INTERNAL_8MHZ_READY = 3;
  localparam int OSCX_ST_INTERNAL_32K_READY  = 2;
  localparam int OSCX_ST_EXT_32K_READY       = 1;
  localparam int OSCX_ST_EXT_CRYSTAL_READY   = 0;
  localparam int OSCX_STATUS_BITS            = 12;

  // ********************************************************
  // Control field positions
  // ********************************************************
  localparam int OSCX_CT_STARTUP_LSB    = 12;
  localparam int OSCX_CT_STARTUP_MSB    = 15;
  localparam int OSCX_CT_GAIN_LSB       = 8;
  localparam int OSCX_CT_GAIN_MSB       = 10;
  localparam int OSCX_CT_RUN_ON_REQUEST = 7;
  localparam int OSCX_CT_RUN_IN_STANDBY = 6;
  localparam int OSCX_CT_CRYSTAL_SELECT = 2;
  localparam int OSCX_CT_ENABLE         = 1;
  localparam logic [15:0] OSCX_CONTROL_MASK = 16'hF7C6;

  // ********************************************************
  // Timing
  // ********************************************************
  localparam logic [1:0]  OSCX_SYNC_CYCLES = 2'h3;

  // AXI responses.
  localparam logic [1:0]  OSCX_RESP_OKAY   = 2'h0;
  localparam logic [1:0]  OSCX_RESP_SLVERR = 2'h2;

  // ********************************************************
  // Types
  // ********************************************************
  // Levels reported by the other clock sources, bits 11 down to 1 of the status word.
  typedef struct packed {
    logic brownout_sync_busy;
    logic brownout_detected;
    logic brownout_detector_ready;
    logic loop_refclk_stopped;
    logic loop_coarse_lock;
    logic loop_fine_lock;
    logic loop_out_of_bounds;
    logic loop_sync_status;
    logic internal_8mhz_ready;
    logic internal_32k_ready;
    logic ext_32k_crystal_ready;
  } oscx_src_status_t;

  // Settings driven out to the crystal oscillator pad cell.
  typedef struct packed {
    logic       run;
    logic       crystal_select;
    logic       run_in_standby;
    logic [2:0] gain;
  } oscx_osc_ctrl_t;

  typedef enum logic [3:0] {
    OSCX_IDLE  = 4'h1,
    OSCX_COUNT = 4'h2,
    OSCX_SYNC  = 4'h4,
    OSCX_READY = 4'h8
  } oscx_state_t;

endpackage

// File: logic/oscx_ctrl.sv
// Clock source status, interrupt flags and external crystal oscillator control with start-up timing.
`timescale 1ns/10ps

// How it works
// - Writing one to the crystal-ready flag clears it; writing zero leaves it.
// - Status register at 0x0C, resets to zero, read-only bits 11:0, rest zero.
// - Bit 11 is one while brownout register synchronization is in progress.
// - Bit 10 is one while brownout detector sees supply below reference.
// - Bit 9 is one when the brownout detector is ready.
// - Bit 8 is one when the loop reference clock has stopped.
// - Bit 7 is one when the loop has coarse lock.
// - Bit 6 is one when the loop has fine lock.
// - Bit 5 is one when the loop is out of bounds.
// - Bit 4 reports the loop synchronization level as the loop gives it.
// - Bit 3 is one only when the internal 8 MHz oscillator is stable.
// - Bit 2 is one only when the internal 32 kHz oscillator is stable.
// - Bit 1 is one only when the external 32 kHz crystal is stable.
// - Bit 0 is one only when the external crystal oscillator is stable.
// - Control register is 16 bits at 0x10, write-protected, resets to 0x0080.
// - Control fields: start-up 15:12, gain 10:8, bits 7, 6, 2, 1.
// - Start-up counter advances on the ultra-low-power 32 kHz clock.
// - Start-up count is two to the power of the start-up code.
// - Three starting-oscillator cycles follow the count before ready is set.
// - Flags set on a rising status bit and request interrupts when enabled.
// - With run-on-request set the oscillator runs only while a peripheral requests it.
// - The enable bit switches the oscillator on and off.
module oscx_ctrl
(
  // Clock and reset
  input  wire logic                       aclk,
  input  wire logic                       aresetn,
  // AXI4-Lite write address
  input  wire logic [7:0]                 s_axi_awaddr,
  input  wire logic                       s_axi_awvalid,
  output logic                            s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0]                s_axi_wdata,
  input  wire logic [3:0]                 s_axi_wstrb,
  input  wire logic                       s_axi_wvalid,
  output logic                            s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]                      s_axi_bresp,
  output logic                            s_axi_bvalid,
  input  wire logic                       s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [7:0]                 s_axi_araddr,
  input  wire logic                       s_axi_arvalid,
  output logic                            s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0]                     s_axi_rdata,
  output logic [1:0]                      s_axi_rresp,
  output logic                            s_axi_rvalid,
  input  wire logic                       s_axi_rready,
  // Other clock sources
  input  wire oscx_pkg::oscx_src_status_t src_status,
  // Crystal oscillator side
  input  wire logic                       ultra_low_power_32k_clock,
  input  wire logic                       ext_crystal_clock,
  input  wire logic                       clock_request,
  input  wire logic                       write_protect,
  output oscx_pkg::oscx_osc_ctrl_t        osc_ctrl,
  // Interrupt request
  output logic                            irq
);
  import oscx_pkg::*;

  // ********************************************************
  // Register state
  // ********************************************************
  logic [15:0]                  control_r;
  logic [OSCX_STATUS_BITS-1:0]  status_r;
  logic [OSCX_STATUS_BITS-1:0]  status_nxt;
  logic [OSCX_STATUS_BITS-1:0]  flag_r;
  logic [OSCX_STATUS_BITS-1:0]  int_enable_r;
  oscx_state_t                  state_r;
  oscx_state_t                  state_nxt;
  logic [16:0]                  count_r;
  logic [1:0]                   sync_r;
  logic                         ulp_prev_r;
  logic                         xtal_prev_r;
  logic                         ulp_tick;
  logic                         xtal_tick;
  logic                         run_nxt;
  logic [16:0]                  startup_len;

  // Bus state.
  logic [7:0]                   aw_addr_r;
  logic                         aw_held_r;
  logic [31:0]                  w_data_r;
  logic [3:0]                   w_strb_r;
  logic                         w_held_r;
  logic                         wr_go;
  logic                         rd_go;
  logic [15:0]                  lane_mask;

  // Byte strobes expanded to a 16-bit mask for the low half-word.
  function automatic logic [15:0] oscx_lane_mask(input logic [3:0] strb);
    oscx_lane_mask = {{8{strb[1]}}, {8{strb[0]}}};
  endfunction

  function automatic logic oscx_hit(input logic [7:0] addr, input logic [7:0] ofs);
    oscx_hit = (addr[7:2] == ofs[7:2]);
  endfunction

  // A function result cannot be sliced, so the strobe mask is held on a net of its own.
  assign lane_mask = oscx_lane_mask(w_strb_r);

  // ********************************************************
  // Start-up sequencer
  // ********************************************************
  // Both slow clocks are sampled as plain inputs; their rising edges become one-cycle ticks.
  assign ulp_tick    = ultra_low_power_32k_clock & ~ulp_prev_r;
  assign xtal_tick   = ext_crystal_clock & ~xtal_prev_r;
  assign startup_len = 17'h0_0001 << control_r[OSCX_CT_STARTUP_MSB:OSCX_CT_STARTUP_LSB];
  assign run_nxt     = control_r[OSCX_CT_ENABLE] & (~control_r[OSCX_CT_RUN_ON_REQUEST] | clock_request);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ulp_prev_r  <= 1'b0;
      xtal_prev_r <= 1'b0;
    end
    else
    begin
      ulp_prev_r  <= ultra_low_power_32k_clock;
      xtal_prev_r <= ext_crystal_clock;
    end
  end

  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      OSCX_IDLE:
        if (run_nxt)
        begin
          state_nxt = OSCX_COUNT;
        end
      OSCX_COUNT:
        if (ulp_tick && (count_r + 17'h0_0001 == startup_len))
        begin
          state_nxt = OSCX_SYNC;
        end
      OSCX_SYNC:
        if (xtal_tick && (sync_r == OSCX_SYNC_CYCLES - 2'h1))
        begin
          state_nxt = OSCX_READY;
        end
      OSCX_READY:
        state_nxt = OSCX_READY;
      default:
        state_nxt = OSCX_IDLE;
    endcase
    if (!run_nxt)
    begin
      state_nxt = OSCX_IDLE;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_r <= OSCX_IDLE;
      count_r <= 17'h0_0000;
      sync_r  <= 2'h0;
    end
    else
    begin
      state_r <= state_nxt;
      if (state_r != OSCX_COUNT || state_nxt != OSCX_COUNT)
      begin
        count_r <= 17'h0_0000;
      end
      else if (ulp_tick)
      begin
        count_r <= count_r + 17'h0_0001;
      end
      if (state_r != OSCX_SYNC || state_nxt != OSCX_SYNC)
      begin
        sync_r <= 2'h0;
      end
      else if (xtal_tick)
      begin
        sync_r <= sync_r + 2'h1;
      end
    end
  end

  // ********************************************************
  // Status and flags
  // ********************************************************
  // Bit 4 carries the loop's own level unchanged, so its sense is whatever the loop reports.
  assign status_nxt = {src_status, (state_nxt == OSCX_READY)};

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      status_r <= OSCX_STATUS_RST[OSCX_STATUS_BITS-1:0];
    end
    else
    begin
      status_r <= status_nxt;
    end
  end

  // A rising edge in the same cycle as a clear keeps the flag set.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      flag_r <= OSCX_FLAG_RST;
    end
    else if (wr_go && oscx_hit(aw_addr_r, OSCX_OFS_INT_FLAG))
    begin
      flag_r <= (flag_r & ~(w_data_r[11:0] & lane_mask[11:0])) | (status_nxt & ~status_r);
    end
    else
    begin
      flag_r <= flag_r | (status_nxt & ~status_r);
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      irq <= 1'b0;
    end
    else
    begin
      irq <= |(flag_r & int_enable_r);
    end
  end

  // ********************************************************
  // Software registers
  // ********************************************************
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      control_r    <= OSCX_CONTROL_RST;
      int_enable_r <= OSCX_ENABLE_RST;
    end
    else if (wr_go)
    begin
      if (oscx_hit(aw_addr_r, OSCX_OFS_CONTROL) && !write_protect)
      begin
        control_r <= (control_r & ~(oscx_lane_mask(w_strb_r) & OSCX_CONTROL_MASK))
                   | (w_data_r[15:0] & oscx_lane_mask(w_strb_r) & OSCX_CONTROL_MASK);
      end
      if (oscx_hit(aw_addr_r, OSCX_OFS_INT_ENABLE))
      begin
        int_enable_r <= (int_enable_r & ~lane_mask[11:0])
                      | (w_data_r[11:0] & lane_mask[11:0]);
      end
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      osc_ctrl <= '0;
    end
    else
    begin
      osc_ctrl.run            <= run_nxt;
      osc_ctrl.crystal_select <= control_r[OSCX_CT_CRYSTAL_SELECT];
      osc_ctrl.run_in_standby <= control_r[OSCX_CT_RUN_IN_STANDBY];
      osc_ctrl.gain           <= control_r[OSCX_CT_GAIN_MSB:OSCX_CT_GAIN_LSB];
    end
  end

  // ********************************************************
  // AXI4-Lite write channel
  // ********************************************************
  assign wr_go = aw_held_r & w_held_r & ~s_axi_bvalid;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held_r     <= 1'b0;
      w_held_r      <= 1'b0;
      aw_addr_r     <= 8'h00;
      w_data_r      <= 32'h0000_0000;
      w_strb_r      <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= OSCX_RESP_OKAY;
    end
    else
    begin
      s_axi_awready <= ~aw_held_r & ~(s_axi_awvalid & s_axi_awready);
      s_axi_wready  <= ~w_held_r & ~(s_axi_wvalid & s_axi_wready);
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held_r <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end
      if (wr_go)
      begin
        aw_held_r    <= 1'b0;
        w_held_r     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        // A status write, or a control write under protection, is accepted and ignored.
        s_axi_bresp  <= (oscx_hit(aw_addr_r, OSCX_OFS_INT_ENABLE) || oscx_hit(aw_addr_r, OSCX_OFS_INT_FLAG)
                      || oscx_hit(aw_addr_r, OSCX_OFS_STATUS) || oscx_hit(aw_addr_r, OSCX_OFS_CONTROL))
                      ? OSCX_RESP_OKAY : OSCX_RESP_SLVERR;
      end
      else if (s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ********************************************************
  // AXI4-Lite read channel
  // ********************************************************
  assign rd_go = s_axi_arvalid & s_axi_arready;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= OSCX_RESP_OKAY;
    end
    else
    begin
      s_axi_arready <= ~s_axi_rvalid & ~rd_go;
      if (rd_go)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= OSCX_RESP_OKAY;
        if (oscx_hit(s_axi_araddr, OSCX_OFS_STATUS))
        begin
          s_axi_rdata <= {20'h0_0000, status_r};
        end
        else if (oscx_hit(s_axi_araddr, OSCX_OFS_CONTROL))
        begin
          s_axi_rdata <= {16'h0000, control_r};
        end
        else if (oscx_hit(s_axi_araddr, OSCX_OFS_INT_FLAG))
        begin
          s_axi_rdata <= {20'h0_0000, flag_r};
        end
        else if (oscx_hit(s_axi_araddr, OSCX_OFS_INT_ENABLE))
        begin
          s_axi_rdata <= {20'h0_0000, int_enable_r};
        end
        else
        begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= OSCX_RESP_SLVERR;
        end
      end
      else if (s_axi_rready)
      begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule

// File: verif/oscx_ctrl_props.sv
// Checker of port relations for the oscillator status and crystal control block.
`timescale 1ns/10ps
module oscx_ctrl_props
(
  // Clock and reset
  input wire logic                       aclk,
  input wire logic                       aresetn,
  // Register bus
  input wire logic [7:0]                 s_axi_araddr,
  input wire logic                       s_axi_arvalid,
  input wire logic                       s_axi_arready,
  input wire logic [31:0]                s_axi_rdata,
  input wire logic [1:0]                 s_axi_rresp,
  input wire logic                       s_axi_rvalid,
  input wire logic                       s_axi_rready,
  input wire logic [1:0]                 s_axi_bresp,
  input wire logic                       s_axi_bvalid,
  input wire logic                       s_axi_bready,
  // Oscillator side
  input wire oscx_pkg::oscx_src_status_t src_status,
  input wire oscx_pkg::oscx_osc_ctrl_t   osc_ctrl,
  input wire logic                       irq
);
  import oscx_pkg::*;
  logic [7:0] rd_addr_r;
  logic [1:0] stable_r;
  logic       rd_unmapped;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      rd_addr_r <= 8'h00;
    else if (s_axi_arvalid && s_axi_arready)
      rd_addr_r <= s_axi_araddr;
  end
  // A status sample is only comparable once the sources held still long enough.
  always_ff @(posedge aclk)
  begin
    if (!aresetn || src_status != $past(src_status))
      stable_r <= 2'h0;
    else if (stable_r != 2'h3)
      stable_r <= stable_r + 2'h1;
  end
  assign rd_unmapped = !(rd_addr_r inside {8'h00, 8'h08, 8'h0C, 8'h10});
  AST_STATUS_UPPER: assert property (s_axi_rvalid && rd_addr_r == 8'h0C |-> s_axi_rdata[31:12] == 20'h00000)
    else $error("status upper bits not zero");
  AST_STATUS_MIRROR: assert property ($rose(s_axi_rvalid) && rd_addr_r == 8'h0C && stable_r == 2'h3
    |-> s_axi_rdata[11:1] == src_status) else $error("status bits differ from sources");
  AST_CTRL_FIELDS: assert property (s_axi_rvalid && rd_addr_r == 8'h10 |-> (s_axi_rdata & 32'hFFFF_0839) == 32'h0)
    else $error("control reserved bits set");
  AST_XTAL_OFF: assert property ($rose(s_axi_rvalid) && rd_addr_r == 8'h0C && !osc_ctrl.run && !$past(osc_ctrl.run)
    && !$past(osc_ctrl.run, 2) && !$past(osc_ctrl.run, 3) |-> !s_axi_rdata[0]) else $error("ready while stopped");
  AST_RD_UNMAPPED: assert property ($rose(s_axi_rvalid) && rd_unmapped |-> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
  AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
    else $error("read answer dropped");
  AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped");
  AST_RESET_QUIET: assert property ($rose(aresetn) |-> !s_axi_bvalid && !s_axi_rvalid && !irq && osc_ctrl == 6'h00)
    else $error("outputs active after reset");
endmodule
bind oscx_ctrl oscx_ctrl_props chk_u (.aclk, .aresetn, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
  .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .src_status, .osc_ctrl, .irq);

// File: verif/oscx_osc_model.sv
// Behavioural model of the low-power and crystal oscillators.
`timescale 1ns/10ps
module oscx_osc_model
#(
  parameter int ULP_HALF  = 5,
  parameter int XTAL_HALF = 2
)
(
  // Clock and reset
  input wire logic                     aclk,
  input wire logic                     aresetn,
  // Crystal control
  input wire oscx_pkg::oscx_osc_ctrl_t osc_ctrl,
  // Oscillator outputs
  output logic                         ulp_clk,
  output logic                         xtal_clk
);
  import oscx_pkg::*;
  int ulp_cnt;
  int xtal_cnt;
  // The low-power oscillator never stops, so it runs free outside reset.
  always @(posedge aclk)
  begin
    if (!aresetn || ulp_cnt == ULP_HALF - 1)
      ulp_cnt <= 0;
    else
      ulp_cnt <= ulp_cnt + 1;
    if (!aresetn)
      ulp_clk <= 1'b0;
    else if (ulp_cnt == ULP_HALF - 1)
      ulp_clk <= ~ulp_clk;
  end
  // A stopped crystal gives no edges at all, so no sync cycle can be counted.
  always @(posedge aclk)
  begin
    if (!aresetn || !osc_ctrl.run)
    begin
      xtal_cnt <= 0;
      xtal_clk <= 1'b0;
    end
    else if (xtal_cnt == XTAL_HALF - 1)
    begin
      xtal_cnt <= 0;
      xtal_clk <= ~xtal_clk;
    end
    else
      xtal_cnt <= xtal_cnt + 1;
  end
endmodule

// File: verif/tb_oscx_ctrl.sv
// Self-checking bench for the oscillator status and crystal control block.
`timescale 1ns/10ps
module tb_oscx_ctrl;
  import oscx_pkg::*;
  localparam int UP = 10;
  localparam int XP = 4;
  logic [7:0]       awaddr, araddr;
  logic [31:0]      wdata, rdata, d;
  logic [3:0]       wstrb;
  logic [1:0]       bresp, rresp, r;
  logic             aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic             arvalid, arready, rvalid, rready, ulp, xtal, req, wp, irq;
  oscx_src_status_t src;
  oscx_osc_ctrl_t   oc;
  int               num_errors, check_count, cyc, t0, el, c;
  always #2.5 aclk = ~aclk;
  always @(posedge aclk) cyc <= cyc + 1;
  oscx_ctrl dut_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .src_status(src), .ultra_low_power_32k_clock(ulp), .ext_crystal_clock(xtal), .clock_request(req),
    .write_protect(wp), .osc_ctrl(oc), .irq(irq));
  oscx_osc_model #(.ULP_HALF(UP / 2), .XTAL_HALF(XP / 2)) osc_u (.aclk(aclk), .aresetn(aresetn), .osc_ctrl(oc),
    .ulp_clk(ulp), .xtal_clk(xtal));
  // ****************************************
  // Bus tasks and comparison
  // ****************************************
  task chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] v);
    logic done;
    done = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!done)
    begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid)
      begin
        r = bresp;
        bready <= 1'b0;
        done = 1'b1;
      end
    end
  endtask
  task rd(input logic [7:0] a);
    logic done;
    done = 1'b0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!done)
    begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid)
      begin
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        done = 1'b1;
      end
    end
  endtask
  task give_verdict();
    $display("checks=%0d errors=%0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // ****************************************
  // Tests
  // ****************************************
  initial
  begin
    aclk = 1'b0;
    {aresetn, awvalid, wvalid, bready, arvalid, rready, req, wp} = 8'h00;
    {awaddr, araddr, wdata, wstrb} = 52'h0;
    wstrb = 4'hF;
    src = 11'h000;
    {num_errors, check_count, cyc} = 96'h0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    rd(OSCX_OFS_STATUS);
    chk(d, 32'h0000_0000);
    rd(OSCX_OFS_CONTROL);
    chk(d, 32'h0000_0080);
    for (int i = 0; i < 11; i++)
    begin
      src <= oscx_src_status_t'(11'h001 << i);
      repeat (4) @(posedge aclk);
      rd(OSCX_OFS_STATUS);
      chk(d, 32'h0000_0002 << i);
    end
    src <= 11'h000;
    wr(OSCX_OFS_CONTROL, 32'h0000_FFFF);
    rd(OSCX_OFS_CONTROL);
    chk(d, 32'h0000_F7C6);
    chk(oc, 32'h0000_001F);
    req <= 1'b1;
    repeat (3) @(posedge aclk);
    chk(oc.run, 1'b1);
    wp <= 1'b1;
    wr(OSCX_OFS_CONTROL, 32'h0000_0000);
    chk(r, 2'h0);
    rd(OSCX_OFS_CONTROL);
    chk(d, 32'h0000_F7C6);
    wp <= 1'b0;
    req <= 1'b0;
    wr(OSCX_OFS_INT_ENABLE, 32'h0000_0001);
    // The slower code proves the count restarts in full after a stop.
    for (int k = 0; k < 2; k++)
    begin
      c = k * 3;
      wr(OSCX_OFS_CONTROL, 32'h0000_0000);
      repeat (4) @(posedge aclk);
      rd(OSCX_OFS_STATUS);
      chk(d[0], 1'b0);
      wr(OSCX_OFS_CONTROL, {16'h0000, c[3:0], 12'h002});
      t0 = cyc;
      d = 32'h0;
      while (d[0] !== 1'b1) rd(OSCX_OFS_STATUS);
      el = cyc - t0;
      chk(el >= (2 ** c - 1) * UP + 2 * XP && el <= (2 ** c + 1) * UP + 4 * XP + 24, 1'b1);
    end
    chk(irq, 1'b1);
    rd(OSCX_OFS_INT_FLAG);
    chk(d[0], 1'b1);
    wr(OSCX_OFS_INT_FLAG, 32'h0000_0000);
    rd(OSCX_OFS_INT_FLAG);
    chk(d[0], 1'b1);
    wr(OSCX_OFS_INT_FLAG, 32'h0000_0FFF);
    rd(OSCX_OFS_INT_FLAG);
    chk(d, 32'h0000_0000);
    chk(irq, 1'b0);
    wr(OSCX_OFS_CONTROL, 32'h0000_0000);
    repeat (4) @(posedge aclk);
    rd(OSCX_OFS_STATUS);
    chk(d[0], 1'b0);
    rd(8'h40);
    chk(r, 2'h2);
    chk(d, 32'h0000_0000);
    wr(8'h44, 32'h0000_0001);
    chk(r, 2'h2);
    give_verdict();
  end
  initial
  begin
    repeat (20000) @(posedge aclk);
    num_errors++;
    give_verdict();
  end
endmodule
